// [core/imd_core.sv]
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// Integer multiply/divide/root/step/abs datapath with APB status view
//
// Contract
// - Enabled multiply writes signed source product
// - Product is 32 bits, low word first
// - Divide writes quotient, then remainder word
// - Zero divisor raises error, no write
// - Square root writes truncated integer root
// - Zero flag set when root is zero
// - Borrow flag set when fraction dropped
// - Negative root source raises operand error
// - Increment wraps maximum to minimum
// - Decrement wraps minimum to maximum
// - Absolute value writes source magnitude
// - Most negative abs source raises operand error
module imd_core (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        op_valid,
  input  wire logic [2:0]  op_code,
  input  wire logic [15:0] first_source,
  input  wire logic [15:0] second_source,
  input  wire logic [15:0] dest_in,
  output logic             busy,
  output logic             res_valid,
  output logic             res_two_words,
  output logic [15:0]      res_lo,
  output logic [15:0]      res_hi,
  output logic             zero_flag,
  output logic             borrow_flag,
  output logic             div_zero_err,
  output logic             operand_err,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_SQRT = 2'b10
  } imd_state_type;

  imd_state_type state_q;
  logic        enable_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic        div_start;
  logic        sqrt_start;
  logic        div_done;
  logic        sqrt_done;
  logic [15:0] quo;
  logic [15:0] rem;
  logic [15:0] root;
  logic        inexact;
  logic        accept;
  logic        apb_acc;
  logic        rd_status;
  logic [2:0]  ev;
  logic [31:0] product;
  logic [15:0] sqrt_src_q;

  // Operations start only when idle and software enable is set
  assign accept     = op_valid && enable_q && state_q == ST_IDLE;
  assign apb_acc    = psel && penable;
  assign product    = 32'($signed(first_source)) * 32'($signed(second_source));
  assign div_start  = accept && op_code == imd_pkg::IMD_OP_DIV
                      && second_source != imd_pkg::WORD_ZERO;
  assign sqrt_start = accept && op_code == imd_pkg::IMD_OP_SQRT && !first_source[15];

  imd_divider #(.W(imd_pkg::WORD_W)) u_div (
    .mclk      (mclk),
    .nrst      (nrst),
    .ce        (ce),
    .start     (div_start),
    .dividend  (first_source),
    .divisor   (second_source),
    .done      (div_done),
    .quotient  (quo),
    .remainder (rem)
  );

  imd_sqrt #(.W(imd_pkg::WORD_W)) u_sqrt (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .start    (sqrt_start),
    .radicand (first_source),
    .done     (sqrt_done),
    .root     (root),
    .inexact  (inexact)
  );

  // Sequencer state; results of the iterative engines land a cycle after done
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      sqrt_src_q <= imd_pkg::WORD_ZERO;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (div_start) begin
            state_q <= ST_DIV;
          end else if (sqrt_start) begin
            state_q    <= ST_SQRT;
            sqrt_src_q <= first_source;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SQRT: begin
          if (sqrt_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Busy output tracks the engines
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else if (ce) begin
      busy <= (div_start || sqrt_start) || (state_q != ST_IDLE && !div_done && !sqrt_done);
    end
  end

  // Result and flag writer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      res_valid     <= 1'b0;
      res_two_words <= 1'b0;
      res_lo        <= imd_pkg::WORD_RESET;
      res_hi        <= imd_pkg::WORD_RESET;
      zero_flag     <= 1'b0;
      borrow_flag   <= 1'b0;
    end else if (ce) begin
      res_valid <= 1'b0;
      if (state_q == ST_DIV && div_done) begin
        res_valid     <= 1'b1;
        res_two_words <= 1'b1;
        res_lo        <= quo;
        res_hi        <= rem;
      end else if (state_q == ST_SQRT && sqrt_done) begin
        res_valid     <= 1'b1;
        res_two_words <= 1'b0;
        res_lo        <= root;
        res_hi        <= imd_pkg::WORD_ZERO;
        zero_flag     <= (root == imd_pkg::WORD_ZERO);
        borrow_flag   <= inexact;
      end else if (accept) begin
        case (op_code)
          imd_pkg::IMD_OP_MUL: begin
            res_valid     <= 1'b1;
            res_two_words <= 1'b1;
            res_lo        <= product[15:0];
            res_hi        <= product[31:16];
          end
          imd_pkg::IMD_OP_INC: begin
            res_valid     <= 1'b1;
            res_two_words <= 1'b0;
            res_lo        <= dest_in + imd_pkg::WORD_ONE;
          end
          imd_pkg::IMD_OP_DEC: begin
            res_valid     <= 1'b1;
            res_two_words <= 1'b0;
            res_lo        <= dest_in - imd_pkg::WORD_ONE;
          end
          imd_pkg::IMD_OP_ABS: begin
            if (first_source != imd_pkg::WORD_MIN) begin
              res_valid     <= 1'b1;
              res_two_words <= 1'b0;
              res_lo        <= first_source[15] ? 16'(-first_source) : first_source;
            end
          end
          default: res_valid <= 1'b0;
        endcase
      end
    end
  end

  // error is high for one enabled cycle per accepted bad request, so it repeats while the request is held; no write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_zero_err <= 1'b0;
      operand_err  <= 1'b0;
    end else if (ce) begin
      div_zero_err <= accept && op_code == imd_pkg::IMD_OP_DIV
                      && second_source == imd_pkg::WORD_ZERO;
      operand_err  <= accept && ((op_code == imd_pkg::IMD_OP_SQRT && first_source[15])
                      || (op_code == imd_pkg::IMD_OP_ABS
                          && first_source == imd_pkg::WORD_MIN));
    end
  end

  // Events: done, divide-by-zero, operand error
  always_comb begin
    ev = '0;
    ev[imd_pkg::IRQ_DONE]  = res_valid;
    ev[imd_pkg::IRQ_DIVZ]  = div_zero_err;
    ev[imd_pkg::IRQ_OPERR] = operand_err;
  end
  assign rd_status = apb_acc && !pwrite && paddr == imd_pkg::REG_STATUS;

  // Sticky status; a read clears only what it reported, so late events survive
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      irq_stat_q <= (rd_status ? (irq_stat_q & ~prdata[2:0]) : irq_stat_q) | ev;
    end
  end

  // Control and mask writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enable_q   <= 1'b0;
      irq_mask_q <= imd_pkg::IRQ_MASK_RESET;
    end else if (ce && apb_acc && pwrite) begin
      if (paddr == imd_pkg::REG_CTRL) begin
        enable_q <= pwdata[imd_pkg::CTRL_ENABLE];
      end
      if (paddr == imd_pkg::REG_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end

  // APB slave: no wait states, read data registered with pready
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end else if (ce) begin
      irq     <= |(irq_stat_q & irq_mask_q);
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          imd_pkg::REG_CTRL:   prdata <= {31'h0, enable_q};
          imd_pkg::REG_STATUS: prdata <= {29'h0, irq_stat_q};
          imd_pkg::REG_MASK:   prdata <= {29'h0, irq_mask_q};
          imd_pkg::REG_RESLO:  prdata <= {16'h0, res_lo};
          imd_pkg::REG_RESHI:  prdata <= {16'h0, res_hi};
          imd_pkg::REG_FLAGS:  prdata <= {28'h0, operand_err, div_zero_err,
                                          borrow_flag, zero_flag};
          default:             pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Checks
  property p_mul_result;
    @(posedge mclk) disable iff (!nrst)
      (ce && accept && op_code == imd_pkg::IMD_OP_MUL) |=>
        res_valid && {res_hi, res_lo} == $past(product);
  endproperty
  a_mul_result: assert property (p_mul_result) else $error("multiply result wrong");

  property p_divz;
    @(posedge mclk) disable iff (!nrst)
      (ce && accept && op_code == imd_pkg::IMD_OP_DIV && second_source == 16'h0000) |=>
        div_zero_err && !res_valid && state_q == ST_IDLE;
  endproperty
  a_divz: assert property (p_divz) else $error("zero divisor not refused");

  property p_div_finish;
    @(posedge mclk) disable iff (!nrst)
      (ce && div_start) |-> ##[1:40] (res_valid && res_two_words);
  endproperty
  a_div_finish: assert property (p_div_finish) else $error("divide never finished");

  property p_sqrt_zero;
    @(posedge mclk) disable iff (!nrst)
      (res_valid && !res_two_words && $past(state_q) == ST_SQRT) |->
        zero_flag == (res_lo == 16'h0000);
  endproperty
  a_sqrt_zero: assert property (p_sqrt_zero) else $error("zero flag mismatch");

  property p_sqrt_borrow;
    @(posedge mclk) disable iff (!nrst)
      (res_valid && $past(state_q) == ST_SQRT) |->
        borrow_flag == ({16'h0, res_lo} * {16'h0, res_lo} != {16'h0, sqrt_src_q});
  endproperty
  a_sqrt_borrow: assert property (p_sqrt_borrow) else $error("borrow flag mismatch");

  property p_opnd_err;
    @(posedge mclk) disable iff (!nrst)
      (ce && accept && op_code == imd_pkg::IMD_OP_SQRT && first_source[15]) |=>
        operand_err && !res_valid ##1 !operand_err;
  endproperty
  a_opnd_err: assert property (p_opnd_err) else $error("negative root accepted");

  property p_inc_wrap;
    @(posedge mclk) disable iff (!nrst)
      (ce && accept && op_code == imd_pkg::IMD_OP_INC && dest_in == 16'h7fff) |=>
        res_valid && res_lo == 16'h8000;
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");

  property p_dec_wrap;
    @(posedge mclk) disable iff (!nrst)
      (ce && accept && op_code == imd_pkg::IMD_OP_DEC && dest_in == 16'h8000) |=>
        res_valid && res_lo == 16'h7fff;
  endproperty
  a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");

  property p_abs_min;
    @(posedge mclk) disable iff (!nrst)
      (ce && accept && op_code == imd_pkg::IMD_OP_ABS && first_source == 16'h8000) |=>
        operand_err && !res_valid && $stable(res_lo);
  endproperty
  a_abs_min: assert property (p_abs_min) else $error("minimum abs accepted");
endmodule

// [core/imd_divider.sv]
`timescale 1ns/1ps
// Sequential signed divider, quotient truncated toward zero
module imd_divider #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic [W-1:0]      quotient,
  output logic [W-1:0]      remainder
);
  logic [W-1:0] num_q;
  logic [W-1:0] den_q;
  logic [W:0]   rem_q;
  logic         qneg_q;
  logic         rneg_q;
  logic [5:0]   cnt_q;
  logic         busy_q;
  logic         fin_q;
  logic [W:0]   trial;

  // One restoring step per enabled cycle on magnitudes
  always_comb begin
    trial = {rem_q[W-1:0], num_q[W-1]} - {1'b0, den_q};
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      num_q     <= '0;
      den_q     <= '0;
      rem_q     <= '0;
      qneg_q    <= 1'b0;
      rneg_q    <= 1'b0;
      cnt_q     <= '0;
      busy_q    <= 1'b0;
      fin_q     <= 1'b0;
      done      <= 1'b0;
      quotient  <= '0;
      remainder <= '0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        num_q  <= dividend[W-1] ? W'(-dividend) : dividend;
        den_q  <= divisor[W-1] ? W'(-divisor) : divisor;
        rem_q  <= '0;
        qneg_q <= dividend[W-1] ^ divisor[W-1];
        rneg_q <= dividend[W-1];
        cnt_q  <= 6'(W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (!trial[W]) begin
          rem_q <= trial;
          num_q <= {num_q[W-2:0], 1'b1};
        end else begin
          rem_q <= {rem_q[W-1:0], num_q[W-1]};
          num_q <= {num_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          fin_q  <= 1'b1;
        end
      end
      // Sign fix-up one cycle after the last step, so it sees the final bits
      if (fin_q) begin
        fin_q     <= 1'b0;
        done      <= 1'b1;
        quotient  <= qneg_q ? W'(-num_q) : num_q;
        remainder <= rneg_q ? W'(-rem_q[W-1:0]) : rem_q[W-1:0];
      end
    end
  end
endmodule

// [core/imd_pkg.sv]
// Package: opcodes, widths, status layout for the integer datapath
package imd_pkg;
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;
  localparam int OPC_W  = 3;
  typedef enum logic [2:0] {
    IMD_OP_MUL  = 3'h0,
    IMD_OP_DIV  = 3'h1,
    IMD_OP_SQRT = 3'h2,
    IMD_OP_INC  = 3'h3,
    IMD_OP_DEC  = 3'h4,
    IMD_OP_ABS  = 3'h5
  } imd_op_type;
  localparam logic [15:0] WORD_MAX   = 16'h7fff;
  localparam logic [15:0] WORD_MIN   = 16'h8000;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [15:0] WORD_ONE   = 16'h0001;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Iterative engine lengths
  localparam int DIV_STEPS  = 16;
  localparam int SQRT_STEPS = 8;
  // Interrupt status bit positions
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_DIVZ   = 1;
  localparam int IRQ_OPERR  = 2;
  localparam int IRQ_W      = 3;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // APB register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK   = 8'h08;
  localparam logic [7:0] REG_RESLO  = 8'h0c;
  localparam logic [7:0] REG_RESHI  = 8'h10;
  localparam logic [7:0] REG_FLAGS  = 8'h14;
  localparam int CTRL_ENABLE = 0;
endpackage

// [core/imd_sqrt.sv]
`timescale 1ns/1ps
// Sequential integer square root, digit by digit
module imd_sqrt #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] radicand,
  output logic              done,
  output logic [W-1:0]      root,
  output logic              inexact
);
  localparam int HW = W / 2;
  logic [W-1:0]  val_q;
  logic [W+1:0]  rem_q;
  logic [HW-1:0] res_q;
  logic [4:0]    cnt_q;
  logic          busy_q;
  logic          fin_q;
  logic [W+1:0]  shifted;
  logic [W+1:0]  trial;

  always_comb begin
    shifted = {rem_q[W-1:0], val_q[W-1:W-2]};
    trial   = shifted - {{(W-HW){1'b0}}, res_q, 2'b01};
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      val_q   <= '0;
      rem_q   <= '0;
      res_q   <= '0;
      cnt_q   <= '0;
      busy_q  <= 1'b0;
      fin_q   <= 1'b0;
      done    <= 1'b0;
      root    <= '0;
      inexact <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        val_q  <= radicand;
        rem_q  <= '0;
        res_q  <= '0;
        cnt_q  <= 5'(HW);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        val_q <= {val_q[W-3:0], 2'b00};
        if (!trial[W+1]) begin
          rem_q <= trial;
          res_q <= {res_q[HW-2:0], 1'b1};
        end else begin
          rem_q <= shifted;
          res_q <= {res_q[HW-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          busy_q <= 1'b0;
          fin_q  <= 1'b1;
        end
      end
      // Publish one cycle after the last step, once the bits have settled
      if (fin_q) begin
        fin_q   <= 1'b0;
        done    <= 1'b1;
        root    <= {{(W-HW){1'b0}}, res_q};
        // Nonzero remainder means a fraction was dropped
        inexact <= (rem_q != '0);
      end
    end
  end
endmodule

// [test/imd_seq_model.sv]
`timescale 1ns/1ps
// Instruction sequencer stand-in that feeds operands to the datapath
module imd_seq_model (
  input  wire logic   mclk,
  output logic        op_valid,
  output logic [2:0]  op_code,
  output logic [15:0] first_source,
  output logic [15:0] second_source,
  output logic [15:0] dest_in
);
  // Idle request lines at time zero
  initial begin
    op_valid      = 1'b0;
    op_code       = 3'h7;
    first_source  = 16'h0000;
    second_source = 16'h0000;
    dest_in       = 16'h0000;
  end

  // One request per call; caller waits out busy
  task automatic issue(input logic [2:0] op, input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] d);
    @(posedge mclk);
    op_valid      <= 1'b1;
    op_code       <= op;
    first_source  <= a;
    second_source <= b;
    dest_in       <= d;
  endtask

  // Drop the request; stale operands flip so the datapath cannot lean on them
  task automatic release_op();
    @(posedge mclk);
    op_valid      <= 1'b0;
    op_code       <= ~op_code;
    first_source  <= ~first_source;
    second_source <= ~second_source;
    dest_in       <= ~dest_in;
  endtask
endmodule

// [test/tb_int16_muldiv_sqrt_incdec_abs.sv]
`timescale 1ns/1ps
// Self-checking bench: queue model of the datapath against the design
module tb_int16_muldiv_sqrt_incdec_abs;
  typedef struct {
    int          kind;
    logic [15:0] lo;
    logic [15:0] hi;
    bit          two;
    bit          sq;
    bit          z;
    bit          b;
  } imd_exp_type;
  logic        mclk, nrst, ce, op_valid, busy, res_valid, res_two_words;
  logic        zero_flag, borrow_flag, div_zero_err, operand_err;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [2:0]  op_code;
  logic [15:0] first_source, second_source, dest_in, res_lo, res_hi, m_lo, m_hi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  op;
  logic [15:0] a, b, d;
  logic [63:0] dv [17];
  bit          m_z, m_b, m_hi_ok, er;
  int          n_errors, checked, cyc;
  imd_exp_type exp_q[$];
  imd_exp_type e;

  imd_core imd_core_i (.mclk(mclk), .nrst(nrst), .ce(ce), .op_valid(op_valid),
    .op_code(op_code), .first_source(first_source), .second_source(second_source),
    .dest_in(dest_in), .busy(busy), .res_valid(res_valid), .res_two_words(res_two_words),
    .res_lo(res_lo), .res_hi(res_hi), .zero_flag(zero_flag), .borrow_flag(borrow_flag),
    .div_zero_err(div_zero_err), .operand_err(operand_err), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  imd_seq_model imd_seq_model_i (.mclk(mclk), .op_valid(op_valid), .op_code(op_code),
    .first_source(first_source), .second_source(second_source), .dest_in(dest_in));

  // 10 MHz clock
  always #50 mclk = ~mclk;

  task automatic stop_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk1(input string n, input logic x, input logic g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", n, x, g);
    end
  endtask

  task automatic chk16(input string n, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk32(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  // Reference arithmetic in plain integers; kind 1 is divide-by-zero, 2 operand error
  function automatic imd_exp_type model(logic [2:0] o, logic [15:0] x, logic [15:0] y,
                                        logic [15:0] w);
    imd_exp_type r;
    int sx, sy, p;
    r = '{0, 16'h0000, 16'h0000, 0, 0, 0, 0};
    sx = int'($signed(x));
    sy = int'($signed(y));
    case (o)
      3'h0: begin
        p = sx * sy;
        r.lo = p[15:0];
        r.hi = p[31:16];
        r.two = 1;
      end
      3'h1: begin
        r.kind = (sy == 0) ? 1 : 0;
        p = (sy == 0) ? 1 : sy;
        r.lo = 16'(sx / p);
        r.hi = 16'(sx % p);
        r.two = 1;
      end
      3'h2: begin
        r.kind = (sx < 0) ? 2 : 0;
        p = 0;
        while ((p + 1) * (p + 1) <= sx) begin
          p++;
        end
        r.lo = p[15:0];
        r.sq = 1;
        r.z = (p == 0);
        r.b = (p * p != sx);
      end
      3'h3: r.lo = w + 16'h0001;
      3'h4: r.lo = w - 16'h0001;
      default: begin
        r.kind = (x == 16'h8000) ? 2 : 0;
        r.lo = (sx < 0) ? 16'(-sx) : x;
      end
    endcase
    return r;
  endfunction

  // Every result or error pulse is matched against the oldest expectation
  always @(posedge mclk) begin
    if (nrst && (res_valid === 1'b1 || div_zero_err === 1'b1 || operand_err === 1'b1)) begin
      if (exp_q.size() == 0) begin
        chk1("unexpected result", 1'b0, 1'b1);
      end else begin
        e = exp_q.pop_front();
        chk1("res_valid", e.kind == 0, res_valid); // Write pulse
        chk1("div_zero_err", e.kind == 1, div_zero_err); // Zero divisor
        chk1("operand_err", e.kind == 2, operand_err); // Range guard
        if (e.kind == 0) begin
          chk1("res_two_words", e.two, res_two_words); // Word count
          m_lo = e.lo;
          m_hi = e.two ? e.hi : m_hi;
          m_hi_ok = e.two;
          m_z = e.sq ? e.z : m_z;
          m_b = e.sq ? e.b : m_b;
        end
        chk16("res_lo", m_lo, res_lo); // Result word
        if (m_hi_ok) begin
          chk16("res_hi", m_hi, res_hi); // Upper word
        end
        chk1("zero_flag", m_z, zero_flag); // Root zero
        chk1("borrow_flag", m_b, borrow_flag); // Dropped fraction
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk1("pready", 1'b1, pready);
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] x, input logic xe);
    apb(1'b0, ad, 32'h0000_0000);
    chk32("prdata", x, rd);
    chk1("pslverr", xe, er);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 60) begin
      @(posedge mclk);
      n++;
    end
    chk32("pending results", 32'h0, 32'(exp_q.size()));
  endtask

  // Slow ops need an empty pipeline and a released request while busy
  task automatic run(input logic [2:0] o, input logic [15:0] x, input logic [15:0] y,
                     input logic [15:0] w);
    bit slow;
    imd_exp_type m;
    slow = (o == 3'h1 || o == 3'h2);
    m = model(o, x, y, w);
    if (slow) begin
      imd_seq_model_i.release_op();
      drain();
    end
    exp_q.push_back(m);
    imd_seq_model_i.issue(o, x, y, w);
    if (slow) begin
      imd_seq_model_i.release_op();
      @(posedge mclk);
      chk1("busy", m.kind == 0, busy); // Engine running
      drain();
    end
  endtask

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {m_lo, m_hi, m_z, m_b, m_hi_ok} = '0;
    dv = '{64'h0_8000_8000_0000, 64'h0_ffff_0001_0000, 64'h0_03e8_07d0_0000,
           64'h1_09c4_03e8_0000, 64'h1_fff9_0002_0000, 64'h1_0005_0000_0000,
           64'h2_0000_0000_0000, 64'h2_03e8_0000_0000, 64'h2_7fff_0000_0000,
           64'h2_0004_0000_0000, 64'h2_8000_0000_0000, 64'h3_0000_0000_7fff,
           64'h4_0000_0000_8000, 64'h3_0000_0000_ffff, 64'h5_fc18_0000_0000,
           64'h5_8000_0000_0000, 64'h5_7fff_0000_0000};
    void'($urandom(43863));
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values of every register, then a hole in the map
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(4 * i), 32'h0, 1'b0);
    end
    rd_chk(8'h20, 32'h0, 1'b1);
    // Disabled: the request must be ignored
    imd_seq_model_i.issue(3'h0, 16'h0002, 16'h0003, 16'h0000);
    imd_seq_model_i.release_op();
    repeat (4) @(posedge mclk);
    apb(1'b1, imd_pkg::REG_CTRL, 32'h0000_0001);
    // Boundary table of all six ops; single-cycle ops back to back, divide and root drained
    foreach (dv[i]) begin
      run(dv[i][50:48], dv[i][47:32], dv[i][31:16], dv[i][15:0]);
    end
    imd_seq_model_i.release_op();
    drain();
    run(3'h0, 16'h0100, 16'h0100, 16'h0000);
    imd_seq_model_i.release_op();
    drain();
    rd_chk(imd_pkg::REG_RESLO, 32'h0000_0000, 1'b0);
    rd_chk(imd_pkg::REG_RESHI, 32'h0000_0001, 1'b0);
    apb(1'b0, imd_pkg::REG_FLAGS, 32'h0);
    chk32("flags", {30'h0, m_b, m_z}, rd & 32'h3);
    // Status sticks until read; the mask gates the interrupt line
    rd_chk(imd_pkg::REG_STATUS, 32'h7, 1'b0);
    rd_chk(imd_pkg::REG_STATUS, 32'h0, 1'b0);
    apb(1'b1, imd_pkg::REG_MASK, 32'h0000_0007);
    rd_chk(imd_pkg::REG_MASK, 32'h7, 1'b0);
    run(3'h1, 16'h0005, 16'h0000, 16'h0000);
    imd_seq_model_i.release_op();
    drain();
    repeat (2) @(posedge mclk);
    chk1("irq", 1'b1, irq);
    rd_chk(imd_pkg::REG_STATUS, 32'h2, 1'b0);
    repeat (2) @(posedge mclk);
    chk1("irq", 1'b0, irq);
    // Random traffic inside the legal operand ranges
    // legal operands
    for (int k = 0; k < 60; k++) begin
      op = 3'($urandom_range(0, 5));
      a = 16'($urandom);
      b = 16'($urandom);
      d = 16'($urandom);
      a = (op == 3'h2) ? (a & 16'h7fff) : a;
      a = (op == 3'h5 && a == 16'h8000) ? 16'h8001 : a;
      b = (op == 3'h1 && (b == 16'h0000 || b == 16'hffff)) ? 16'h0007 : b;
      run(op, a, b, d);
    end
    imd_seq_model_i.release_op();
    drain();
    stop_test();
  end
endmodule
